// >>> urs_cfg.svh
`ifndef URS_CFG_SVH
`define URS_CFG_SVH
// Register byte offsets
`define URS_OFS_STATUS 12'h000
`define URS_OFS_DATA 12'h004
`define URS_OFS_CTRL1 12'h008
`define URS_OFS_CTRL2 12'h00c
`define URS_OFS_BAUD 12'h010
// Status fields
`define URS_ST_PARITY_ERR_FLAG 0
`define URS_ST_FRAME_ERR_FLAG 1
`define URS_ST_NOISE 2
`define URS_ST_OVERRUN 3
`define URS_ST_IDLE 4
`define URS_ST_READY 5
`define URS_ST_TXIDLE 6
`define URS_ST_TXEMPTY 7
// Control one fields
`define URS_C1_RXEN 0
`define URS_C1_NINE 1
`define URS_C1_PAREN 2
`define URS_C1_PARODD 3
`define URS_C1_TWOSTOP 4
// Control two fields
`define URS_C2_RXIE 0
`define URS_C2_TXEIE 1
`define URS_C2_TXIIE 2
`define URS_C2_ADDR 3
`define URS_C2_WAKE 4
// Reset values
`define URS_CTRL_RST 8'h00
`define URS_BAUD_RST 16'h0000
// Oversampling: ticks per bit and vote sample points
`define URS_OVS_LAST 4'hf
`define URS_VOTE_END 4'h9
`define URS_BITS_EIGHT 4'h8
`define URS_BITS_NINE 4'h9
`endif

// >>> urs_line_model.sv
`timescale 1ns/10ps
module urs_line_model #(
    parameter int BIT_CLKS = 16
) (
    // Clock and pacing
    input wire logic pclk,
    input wire logic port_clk_en,
    // Serial line, idle high
    output logic rx_pin
);
    // ****
    // Remote transmitter
    // ****
    initial rx_pin = 1'b1;
    // Paced by the gate too, so a stopped port sees a frozen line
    task automatic level(input logic v, input int n);
        int k;
        k = 0;
        rx_pin <= v;
        while (k < n) begin
            @(posedge pclk);
            if (port_clk_en) begin
                k++;
            end
        end
    endtask : level
    task automatic send(input logic [8:0] d, input int nb = 8, input logic po = 1'b0,
        input logic pb = 1'b0, input logic st = 1'b1, input int gb = -1, input int go = 0);
        logic b;
        int n;
        n = nb + (po ? 3 : 2);
        for (int i = 0; i < n; i++) begin
            b = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (po && i == nb + 1) ? pb : st;
            if (i == gb) begin
                level(b, go);
                level(!b, 1);
                level(b, BIT_CLKS - 1 - go);
            end else begin
                level(b, BIT_CLKS);
            end
        end
    endtask : send
endmodule : urs_line_model

// >>> urs_pkg.sv
package urs_pkg;
    typedef enum logic [2:0] {
        URS_IDLE, URS_START, URS_DATA, URS_PARITY, URS_STOP, URS_WAIT_HIGH
    } urs_state_type;
endpackage : urs_pkg

// >>> urs_rx_status.sv
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "urs_cfg.svh"

module urs_rx_status
    import urs_pkg::*;
#(
    parameter int DATA_W = 9
) (
    // Clock, reset and port clock gate
    input wire logic pclk,
    input wire logic presetn,
    input wire logic port_clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line
    input wire logic rx_pin,
    // Transmitter conditions
    input wire logic tx_buf_empty,
    input wire logic tx_idle,
    // Merged interrupt request
    output logic uart_int_n
);

    // ********************************
    // Registers and bus decode
    // ********************************
    logic [7:0] control_reg_one;
    logic [7:0] control_reg_two;
    logic [15:0] baud_divisor;
    logic access;
    logic setup;
    logic hit_status;
    logic hit_data;
    logic hit_ctrl1;
    logic hit_ctrl2;
    logic hit_baud;
    logic mapped;
    logic status_read;
    logic data_read;

    assign access = psel & penable & port_clk_en;
    assign setup = psel & ~penable;
    assign hit_status = paddr == `URS_OFS_STATUS;
    assign hit_data = paddr == `URS_OFS_DATA;
    assign hit_ctrl1 = paddr == `URS_OFS_CTRL1;
    assign hit_ctrl2 = paddr == `URS_OFS_CTRL2;
    assign hit_baud = paddr == `URS_OFS_BAUD;
    assign mapped = hit_status | hit_data | hit_ctrl1 | hit_ctrl2 | hit_baud;
    // Stalls while the port clock is stopped so no access is lost
    assign pready = port_clk_en;
    assign pslverr = psel & penable & ~mapped;
    assign status_read = access & ~pwrite & hit_status;
    assign data_read = access & ~pwrite & hit_data;

    logic rx_enable;
    logic nine_bit_select;
    logic parity_enable;
    logic parity_odd;
    logic rx_int_enable;
    logic tx_empty_int_enable;
    logic tx_idle_int_enable;
    logic addr_detect_enable;
    logic wake_enable;

    assign rx_enable = control_reg_one[`URS_C1_RXEN];
    assign nine_bit_select = control_reg_one[`URS_C1_NINE];
    assign parity_enable = control_reg_one[`URS_C1_PAREN];
    assign parity_odd = control_reg_one[`URS_C1_PARODD];
    assign rx_int_enable = control_reg_two[`URS_C2_RXIE];
    assign tx_empty_int_enable = control_reg_two[`URS_C2_TXEIE];
    assign tx_idle_int_enable = control_reg_two[`URS_C2_TXIIE];
    assign addr_detect_enable = control_reg_two[`URS_C2_ADDR];
    assign wake_enable = control_reg_two[`URS_C2_WAKE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg_one <= `URS_CTRL_RST;
            control_reg_two <= `URS_CTRL_RST;
            baud_divisor <= `URS_BAUD_RST;
        end else if (access && pwrite) begin
            if (hit_ctrl1) begin
                control_reg_one <= pwdata[7:0];
            end
            if (hit_ctrl2) begin
                control_reg_two <= pwdata[7:0];
            end
            if (hit_baud) begin
                baud_divisor <= pwdata[15:0];
            end
        end
    end

    // ********************************
    // Line synchroniser
    // ********************************
    // Runs free so that wake-up can see the line while the port clock is off
    logic rx_meta;
    logic rx_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
        end
    end

    // ********************************
    // Oversampling tick
    // ********************************
    logic [15:0] div_cnt;
    logic tick;

    assign tick = port_clk_en && (div_cnt == baud_divisor);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
        end else if (port_clk_en) begin
            if (tick) begin
                div_cnt <= 16'h0000;
            end else begin
                div_cnt <= div_cnt + 16'h0001;
            end
        end
    end

    // ********************************
    // Receive shifter
    // ********************************
    urs_state_type state;
    logic [3:0] ovs_cnt;
    logic [3:0] bit_cnt;
    logic [1:0] samples;
    logic vote;
    logic noisy;
    logic bit_done;
    logic [DATA_W-1:0] rx_shift_reg;
    logic parity_bit;
    logic frame_noise;
    logic [3:0] word_bits;
    logic [DATA_W-1:0] word;
    logic word_parity_err;
    logic word_frame_err;
    logic word_done;
    logic rx_idle_flag;

    assign vote = (samples[1] & samples[0]) | (samples[1] & rx_sync) | (samples[0] & rx_sync);
    assign noisy = !((samples[1] == samples[0]) && (samples[0] == rx_sync));
    assign bit_done = tick && (ovs_cnt == `URS_VOTE_END);
    assign word_bits = nine_bit_select ? `URS_BITS_NINE : `URS_BITS_EIGHT;
    assign word = nine_bit_select ? rx_shift_reg : {1'b0, rx_shift_reg[DATA_W-1:1]};
    assign word_parity_err = parity_enable && ((^word ^ parity_bit) != parity_odd);
    assign word_frame_err = !vote;
    assign word_done = bit_done && (state == URS_STOP);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samples <= 2'b11;
        end else if (tick) begin
            samples <= {samples[0], rx_sync};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= URS_IDLE;
            ovs_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            rx_shift_reg <= '0;
            parity_bit <= 1'b0;
            frame_noise <= 1'b0;
        end else if (!rx_enable && port_clk_en) begin
            state <= URS_IDLE;
        end else if (tick) begin
            ovs_cnt <= ovs_cnt + 4'h1;
            unique case (state)
                URS_IDLE: begin
                    if (!rx_sync) begin
                        state <= URS_START;
                        ovs_cnt <= 4'h1;
                        frame_noise <= 1'b0;
                    end
                end
                URS_START: begin
                    if (bit_done) begin
                        frame_noise <= noisy;
                        bit_cnt <= 4'h0;
                        if (vote) begin
                            state <= URS_IDLE;
                        end
                    end
                    if (ovs_cnt == `URS_OVS_LAST && state == URS_START) begin
                        state <= URS_DATA;
                    end
                end
                URS_DATA: begin
                    if (bit_done) begin
                        rx_shift_reg <= {vote, rx_shift_reg[DATA_W-1:1]};
                        frame_noise <= frame_noise | noisy;
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (ovs_cnt == `URS_OVS_LAST && bit_cnt == word_bits) begin
                        state <= parity_enable ? URS_PARITY : URS_STOP;
                    end
                end
                URS_PARITY: begin
                    if (bit_done) begin
                        parity_bit <= vote;
                        frame_noise <= frame_noise | noisy;
                    end
                    if (ovs_cnt == `URS_OVS_LAST) begin
                        state <= URS_STOP;
                    end
                end
                URS_STOP: begin
                    if (bit_done) begin
                        state <= vote ? URS_IDLE : URS_WAIT_HIGH;
                    end
                end
                URS_WAIT_HIGH: begin
                    if (rx_sync) begin
                        state <= URS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_idle_flag <= 1'b1;
        end else if (tick && state == URS_IDLE && !rx_sync && rx_enable) begin
            rx_idle_flag <= 1'b0;
        end else if (word_done || (bit_done && state == URS_START && vote)) begin
            // A false start is no frame, so the receiver counts as idle again
            rx_idle_flag <= 1'b1;
        end
    end

    // ********************************
    // Two-word receive buffer
    // ********************************
    // Each entry: parity error, framing error, word
    logic [DATA_W+1:0] rx_data_fifo [2];
    logic [1:0] fifo_count;
    logic rd_ptr;
    logic wr_ptr;
    logic fifo_full;
    logic push;
    logic pop;
    logic overrun_event;
    logic [DATA_W+1:0] head;

    assign fifo_full = fifo_count == 2'd2;
    assign push = word_done && !fifo_full;
    assign overrun_event = word_done && fifo_full;
    assign pop = data_read && (fifo_count != 2'd0);
    assign head = rx_data_fifo[rd_ptr];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_fifo[0] <= '0;
            rx_data_fifo[1] <= '0;
        end else if (push) begin
            rx_data_fifo[wr_ptr] <= {word_parity_err, word_frame_err, word};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_count <= 2'd0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            fifo_count <= fifo_count + {1'b0, push} - {1'b0, pop};
        end
    end

    // ********************************
    // Status flags and clearing sequence
    // ********************************
    logic clear_armed;
    logic seq_clear;
    logic overrun_flag;
    logic noise_flag;
    logic rx_ready_flag;
    logic frame_err_flag;
    logic parity_err_flag;

    assign seq_clear = data_read && clear_armed;
    assign rx_ready_flag = fifo_count != 2'd0;
    assign frame_err_flag = rx_ready_flag && head[DATA_W];
    assign parity_err_flag = rx_ready_flag && head[DATA_W+1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_armed <= 1'b0;
        end else if (status_read) begin
            clear_armed <= 1'b1;
        end else if (data_read) begin
            clear_armed <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_flag <= 1'b0;
            noise_flag <= 1'b0;
        end else begin
            if (overrun_event) begin
                overrun_flag <= 1'b1;
            end else if (seq_clear) begin
                overrun_flag <= 1'b0;
            end
            if (push && frame_noise) begin
                noise_flag <= 1'b1;
            end else if (seq_clear) begin
                noise_flag <= 1'b0;
            end
        end
    end

    // ********************************
    // Read data
    // ********************************
    logic [31:0] next_prdata;

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_status) begin
            next_prdata[`URS_ST_PARITY_ERR_FLAG] = parity_err_flag;
            next_prdata[`URS_ST_FRAME_ERR_FLAG] = frame_err_flag;
            next_prdata[`URS_ST_NOISE] = noise_flag;
            next_prdata[`URS_ST_OVERRUN] = overrun_flag;
            next_prdata[`URS_ST_IDLE] = rx_idle_flag;
            next_prdata[`URS_ST_READY] = rx_ready_flag;
            next_prdata[`URS_ST_TXIDLE] = tx_idle;
            next_prdata[`URS_ST_TXEMPTY] = tx_buf_empty;
        end else if (hit_data) begin
            next_prdata[DATA_W-1:0] = rx_ready_flag ? head[DATA_W-1:0] : '0;
        end else if (hit_ctrl1) begin
            next_prdata[7:0] = control_reg_one;
        end else if (hit_ctrl2) begin
            next_prdata[7:0] = control_reg_two;
        end else if (hit_baud) begin
            next_prdata[15:0] = baud_divisor;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ********************************
    // Merged interrupt
    // ********************************
    logic addr_ok;
    logic rx_event;
    logic tx_empty_q;
    logic tx_idle_q;
    logic tx_event;
    logic int_pulse;
    logic wake_req;

    assign addr_ok = !addr_detect_enable || (nine_bit_select ? word[8] : word[7]);
    assign rx_event = rx_int_enable && ((push && addr_ok) || overrun_event);
    assign tx_event = (tx_empty_int_enable && tx_buf_empty && !tx_empty_q)
        || (tx_idle_int_enable && tx_idle && !tx_idle_q);
    assign wake_req = !port_clk_en && wake_enable && rx_int_enable && rx_enable && !rx_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_empty_q <= 1'b0;
            tx_idle_q <= 1'b0;
            int_pulse <= 1'b0;
        end else if (port_clk_en) begin
            tx_empty_q <= tx_buf_empty;
            tx_idle_q <= tx_idle;
            int_pulse <= rx_event || tx_event;
        end else begin
            int_pulse <= 1'b0;
        end
    end

    assign uart_int_n = !(int_pulse || wake_req);

endmodule : urs_rx_status

// >>> urs_rx_status_assertions.sv
`timescale 1ns/10ps
`include "urs_cfg.svh"
module urs_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic port_clk_en,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Line, transmitter and interrupt
    input wire logic rx_pin,
    input wire logic tx_buf_empty,
    input wire logic tx_idle,
    input wire logic uart_int_n
);
    // ****
    // Control shadow
    // ****
    logic [4:0] c2;
    logic rx_en;
    logic wr_ok;
    assign wr_ok = psel && penable && pready && pwrite;
    // Enables are only visible through the writes that set them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c2 <= 5'h00;
            rx_en <= 1'b0;
        end else if (wr_ok && paddr == `URS_OFS_CTRL2) begin
            c2 <= pwdata[4:0];
        end else if (wr_ok && paddr == `URS_OFS_CTRL1) begin
            rx_en <= pwdata[`URS_C1_RXEN];
        end
    end
    // ****
    // Properties
    // ****
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence empty_rise;
        port_clk_en && c2[1] && !tx_buf_empty ##1 port_clk_en && tx_buf_empty;
    endsequence
    sequence idle_rise;
        port_clk_en && c2[2] && !tx_idle ##1 port_clk_en && tx_idle;
    endsequence
    sequence line_low;
        !rx_pin [*3];
    endsequence
    pready_gate_a: assert property (pready == port_clk_en)
        else $error("pready does not follow the gate");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    data_hold_a: assert property ($changed(prdata) |-> $past(psel && !pwrite))
        else $error("read data moved without a read");
    reset_quiet_a: assert property (@(posedge pclk) disable iff (1'b0)
        !presetn |-> uart_int_n && prdata == 32'h0)
        else $error("outputs active in reset");
    empty_int_a: assert property (empty_rise |-> ##[1:2] !uart_int_n)
        else $error("no pulse on tx empty");
    idle_int_a: assert property (idle_rise |-> ##[1:2] !uart_int_n)
        else $error("no pulse on tx idle");
    int_pulse_a: assert property (port_clk_en && !uart_int_n ##1 port_clk_en |-> uart_int_n)
        else $error("interrupt low beyond one cycle");
    wake_level_a: assert property ((!port_clk_en && c2[4] && c2[0] && rx_en)
        throughout line_low |-> !uart_int_n)
        else $error("no wake request");
    int_masked_a: assert property (c2 == 5'h00 && $past(c2) == 5'h00 |-> uart_int_n)
        else $error("interrupt with all enables off");
endmodule : urs_chk

bind urs_rx_status urs_chk u_chk (.pclk(pclk), .presetn(presetn), .port_clk_en(port_clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .tx_buf_empty(tx_buf_empty), .tx_idle(tx_idle), .uart_int_n(uart_int_n));

// >>> urs_rx_status_tb.sv
`timescale 1ns/10ps
`include "urs_cfg.svh"
module urs_rx_status_tb;
    // ****
    // Bench
    // ****
    localparam logic [11:0] ST = `URS_OFS_STATUS;
    localparam logic [11:0] DT = `URS_OFS_DATA;
    localparam logic [11:0] C1 = `URS_OFS_CTRL1;
    localparam logic [11:0] C2 = `URS_OFS_CTRL2;
    logic pclk, presetn, port_clk_en, psel, penable, pwrite, tx_buf_empty, tx_idle;
    logic pready, pslverr, rx_pin, uart_int_n, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] d;
    int mismatches, tests_run, ints, n;
    urs_rx_status dut (.pclk(pclk), .presetn(presetn), .port_clk_en(port_clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
        .tx_buf_empty(tx_buf_empty), .tx_idle(tx_idle), .uart_int_n(uart_int_n));
    urs_line_model remote (.pclk(pclk), .port_clk_en(port_clk_en), .rx_pin(rx_pin));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (presetn && !uart_int_n) begin
            ints++;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge pclk);
        end while (!pready);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic summarize;
        $display("tests %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    initial begin
        #200000;
        mismatches++;
        summarize();
    end
    initial begin
        {presetn, psel, penable, pwrite, tx_buf_empty, tx_idle} = 6'h00;
        port_clk_en = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        {mismatches, tests_run, ints} = 96'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(ST, 32'h10);
        rdc(C1, 32'h0);
        rdc(C2, 32'h0);
        rdc(`URS_OFS_BAUD, 32'h0);
        xfer(1'b0, 12'h020, 32'h0);
        chk(32'(er), 32'h1);
        xfer(1'b1, ST, 32'hff);
        rdc(ST, 32'h10);
        $display("map done");
        xfer(1'b1, C1, 32'h01);
        xfer(1'b1, C2, 32'h01);
        ints = 0;
        fork
            remote.send(9'h0a5);
            begin
                repeat (48) @(posedge pclk);
                rdc(ST, 32'h00);
            end
        join
        chk(ints, 32'h1);
        rdc(ST, 32'h30);
        rdc(DT, 32'ha5);
        rdc(ST, 32'h10);
        ints = 0;
        for (int i = 1; i <= 3; i++) begin
            remote.send(9'(i * 17));
        end
        chk(ints, 32'h3);
        rdc(ST, 32'h38);
        rdc(DT, 32'h11);
        rdc(ST, 32'h30);
        rdc(DT, 32'h22);
        rdc(ST, 32'h10);
        rdc(DT, 32'h00);
        $display("buffer done");
        remote.send(9'h05a, 8, 1'b0, 1'b0, 1'b0);
        remote.level(1'b1, 32);
        rdc(ST, 32'h32);
        rdc(DT, 32'h5a);
        ints = 0;
        remote.level(1'b0, 320);
        remote.level(1'b1, 32);
        chk(ints, 32'h1);
        rdc(ST, 32'h32);
        rdc(DT, 32'h00);
        rdc(ST, 32'h10);
        $display("break done");
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, C1, k[1] ? 32'h0d : 32'h05);
            remote.send(9'h0c3, 8, 1'b1, k[1] ^ k[0]);
            rdc(ST, {31'h18, k[0]});
            rdc(DT, 32'hc3);
        end
        xfer(1'b1, C1, 32'h01);
        n = 0;
        for (int g = 2; g < 14; g++) begin
            remote.send(9'h0b4, 8, 1'b0, 1'b0, 1'b1, 3, g);
            xfer(1'b0, ST, 32'h0);
            n = n + int'(rd[2] === 1'b1);
            chk(rd & ~32'h4, 32'h30);
            rdc(DT, 32'hb4);
        end
        chk(n, 32'h3);
        rdc(ST, 32'h10);
        $display("errors done");
        xfer(1'b1, C2, 32'h09);
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, C1, k[1] ? 32'h03 : 32'h01);
            d = k[0] ? (k[1] ? 9'h100 : 9'h080) : (k[1] ? 9'h0ff : 9'h07f);
            ints = 0;
            remote.send(d, k[1] ? 9 : 8);
            chk(ints, 32'(k[0]));
            rdc(DT, {23'h0, d});
        end
        xfer(1'b1, C1, 32'h01);
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, C2, k[0] ? 32'h02 : 32'h04);
            ints = 0;
            tx_buf_empty <= k[1];
            tx_idle <= !k[1];
            repeat (4) @(posedge pclk);
            chk(ints, 32'(k[0] == k[1]));
            {tx_buf_empty, tx_idle} <= 2'b00;
            @(posedge pclk);
        end
        xfer(1'b1, C2, 32'h00);
        ints = 0;
        remote.send(9'h011);
        chk(ints, 32'h0);
        rdc(DT, 32'h11);
        $display("interrupts done");
        xfer(1'b1, C2, 32'h11);
        fork
            remote.send(9'h03c);
            begin
                repeat (60) @(posedge pclk);
                port_clk_en <= 1'b0;
                repeat (50) @(posedge pclk);
                port_clk_en <= 1'b1;
            end
        join
        rdc(ST, 32'h30);
        rdc(DT, 32'h3c);
        rdc(C2, 32'h11);
        port_clk_en <= 1'b0;
        fork
            remote.level(1'b0, 2);
            begin
                repeat (5) @(posedge pclk);
                chk(32'(uart_int_n), 32'h0);
                port_clk_en <= 1'b1;
            end
        join
        remote.level(1'b1, 48);
        rdc(ST, 32'h10);
        $display("power done");
        summarize();
    end
endmodule : urs_rx_status_tb
